// ===== ssms_mode_select.v
/*
 Stepper stage mode selector: decodes the four rotary switches into
 switch, bus or deactivated mode, holds the effective currents, step
 resolution and direction, serves the configuration registers over
 Avalon-MM and drives the bi-colour status LED.
 Assumes all inputs are synchronous to clk; resetIn is the stage's
 external reset input and is level, a rise counts as one reset event.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
// How it works
// - Switches not all zero and S2..S4 nonzero give switch mode from switches.
// - Bus mode only when switches two, three and four all read zero, or while the bus-exclusive lock is set.
// - In bus mode the address switch gives the address, 0 to F.
// - Some but not all of switches two to four at zero deactivates the stage.
// - With the bus-exclusive lock set, switch settings are ignored.
// - Switch values are sampled on a reset event and in the first cycle after reset.
// - Bus writes work in switch mode too, until a reset reloads switches.
// - In bus mode writes act at once; new resolution waits for reset.
// - Current and step switches use 1 to F; address switch uses 0 to F.
// - Switch currents step 0.1 A in low range, 0.3 A in high range.
// - Switch mode offers full, half, 1/4, 1/5, 1/8, 1/10, 1/20 step.
// - Bus mode offers full through 1/512 step.
// - Bus run and stop currents set separately, 0.1 to 5 A, 100 mA steps.
// - Green steady when the stage is ready and energised.
// - Green blinks at 0.5 Hz while the stage is deactivated.
// - Red steady on overcurrent, 0.5 Hz on undervoltage, 2 Hz overtemperature.
// - After reset the lock is clear and defaults apply.
`timescale 1ns/1ps
`include "ssms_defines.vh"

module ssms_mode_select #(
    parameter SLOW_HALF_CYCLES = `SSMS_CLK_HZ / 1000 * `SSMS_SLOW_HALF_MS,
    parameter FAST_HALF_CYCLES = `SSMS_CLK_HZ / 1000 * `SSMS_FAST_HALF_MS
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Avalon-MM slave
    input  wire [4:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    // Front panel
    input  wire [3:0]  address_switch,
    input  wire [3:0]  run_current_switch,
    input  wire [3:0]  stop_current_switch,
    input  wire [3:0]  resolution_direction_switch,
    input  wire        rangeHigh,
    input  wire        resetIn,
    // Stage state
    input  wire        activation,
    input  wire        overCurrent,
    input  wire        underVoltage,
    input  wire        overTemperature,
    // Effective settings
    output reg  [2:0]  opMode,
    output reg  [3:0]  busAddress,
    output reg  [5:0]  runCurrent,
    output reg  [5:0]  stopCurrent,
    output reg  [3:0]  stepResolution,
    output reg         reverseDirection,
    output reg         stageDisabled,
    // Status LED
    output reg         ledGreen,
    output reg         ledRed
);
    // Bus handshake: one wait cycle, then the answer
    reg ack_q;
    wire busReq  = avsRead | avsWrite;
    wire accept  = busReq & ack_q;
    wire wrTaken = avsWrite & ack_q & avsByteEnable[0];
    assign avsWaitRequest = busReq & ~ack_q;

    reg       lock_q;
    reg       resetIn_q;
    reg       load_q;
    reg [3:0] pendRes_q;
    wire      resetEvent = resetIn & ~resetIn_q;

    // Switch decoding
    wire s2Zero = (run_current_switch == 4'h0);
    wire s3Zero = (stop_current_switch == 4'h0);
    wire s4Zero = (resolution_direction_switch == 4'h0);
    wire allZero = s2Zero & s3Zero & s4Zero;
    wire anyZero = s2Zero | s3Zero | s4Zero;
    reg  [2:0] decodedMode;

    always @* begin
        if (allZero)
            decodedMode = `SSMS_MODE_BUS;
        else if (anyZero)
            decodedMode = `SSMS_MODE_DEACT;
        else
            decodedMode = `SSMS_MODE_SWITCH;
    end

    wire [5:0] runSwCur;
    wire [5:0] stopSwCur;

    ssms_current_map runMap (
        .position  (run_current_switch),
        .rangeHigh (rangeHigh),
        .tenthAmps (runSwCur)
    );

    ssms_current_map stopMap (
        .position  (stop_current_switch),
        .rangeHigh (rangeHigh),
        .tenthAmps (stopSwCur)
    );

    // Step switch: 1..7 forward, 8..E reverse, F reverse full step
    reg [3:0] swRes;
    reg       swDir;
    always @* begin
        swDir = (resolution_direction_switch >= 4'h8);
        case (resolution_direction_switch)
            4'h1, 4'h8, 4'hf: swRes = `SSMS_STEP_1;
            4'h2, 4'h9:       swRes = `SSMS_STEP_2;
            4'h3, 4'ha:       swRes = `SSMS_STEP_4;
            4'h4, 4'hb:       swRes = `SSMS_STEP_5;
            4'h5, 4'hc:       swRes = `SSMS_STEP_8;
            4'h6, 4'hd:       swRes = `SSMS_STEP_10;
            4'h7, 4'he:       swRes = `SSMS_STEP_20;
            default:          swRes = `SSMS_STEP_1;
        endcase
    end

    // Bus current writes are clamped into the legal range
    wire [5:0] wrCur = avsWriteData[5:0];
    wire [5:0] wrCurClamped = (wrCur < `SSMS_CUR_MIN) ? `SSMS_CUR_MIN :
                              (wrCur > `SSMS_CUR_MAX) ? `SSMS_CUR_MAX : wrCur;
    wire [3:0] wrRes = avsWriteData[`SSMS_RES_CODE_MSB:0];
    wire       wrResOk = (wrRes <= `SSMS_STEP_512);
    wire       inBus = opMode[1];

    always @(posedge clk) begin
        if (reset) begin
            ack_q            <= 1'b0;
            lock_q           <= 1'b0;
            resetIn_q        <= 1'b0;
            load_q           <= 1'b1;
            pendRes_q        <= `SSMS_RST_RES;
            opMode           <= `SSMS_MODE_DEACT;
            busAddress       <= `SSMS_RST_ADDR;
            runCurrent       <= `SSMS_RST_CURRENT;
            stopCurrent      <= `SSMS_RST_CURRENT;
            stepResolution   <= `SSMS_RST_RES;
            reverseDirection <= 1'b0;
        end else begin
            ack_q     <= busReq & ~ack_q;
            resetIn_q <= resetIn;
            // Switches are caught one cycle after a reset, never while running
            load_q    <= resetEvent;
            if (load_q) begin
                if (lock_q) begin
                    opMode         <= `SSMS_MODE_BUS;
                    stepResolution <= pendRes_q;
                end else begin
                    opMode     <= decodedMode;
                    busAddress <= address_switch;
                    case (decodedMode)
                        `SSMS_MODE_SWITCH: begin
                            runCurrent       <= runSwCur;
                            stopCurrent      <= stopSwCur;
                            stepResolution   <= swRes;
                            reverseDirection <= swDir;
                            pendRes_q        <= swRes;
                        end
                        `SSMS_MODE_BUS: begin
                            stepResolution <= pendRes_q;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // Bus writes come last so a write in the load cycle survives
            if (wrTaken) begin
                case (avsAddress)
                    `SSMS_OFS_CONTROL:
                        lock_q <= avsWriteData[`SSMS_CTRL_LOCK_BIT];
                    `SSMS_OFS_RUN_CURRENT:
                        runCurrent <= wrCurClamped;
                    `SSMS_OFS_STOP_CURRENT:
                        stopCurrent <= wrCurClamped;
                    `SSMS_OFS_RESOLUTION: begin
                        reverseDirection <= avsWriteData[`SSMS_RES_DIR_BIT];
                        if (wrResOk) begin
                            pendRes_q <= wrRes;
                            if (!inBus)
                                stepResolution <= wrRes;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data is formed in the wait cycle and stands in the answer cycle
    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h0;
        case (avsAddress)
            `SSMS_OFS_CONTROL:      rdMux[`SSMS_CTRL_LOCK_BIT] = lock_q;
            `SSMS_OFS_RUN_CURRENT:  rdMux[5:0] = runCurrent;
            `SSMS_OFS_STOP_CURRENT: rdMux[5:0] = stopCurrent;
            `SSMS_OFS_RESOLUTION: begin
                rdMux[`SSMS_RES_CODE_MSB:0] = pendRes_q;
                rdMux[`SSMS_RES_DIR_BIT]    = reverseDirection;
            end
            `SSMS_OFS_STATUS: begin
                rdMux[`SSMS_ST_MODE_LSB+2:`SSMS_ST_MODE_LSB] = opMode;
                rdMux[`SSMS_ST_DEACT_BIT]                    = stageDisabled;
                rdMux[`SSMS_ST_ADDR_LSB+3:`SSMS_ST_ADDR_LSB] = busAddress;
                rdMux[`SSMS_ST_RES_LSB+3:`SSMS_ST_RES_LSB]   = stepResolution;
                rdMux[`SSMS_ST_DIR_BIT]                      = reverseDirection;
                rdMux[`SSMS_ST_RANGE_BIT]                    = rangeHigh;
                rdMux[`SSMS_ST_OC_BIT]                       = overCurrent;
                rdMux[`SSMS_ST_UV_BIT]                       = underVoltage;
                rdMux[`SSMS_ST_OT_BIT]                       = overTemperature;
            end
            default: rdMux = 32'h0;
        endcase
    end

    always @(posedge clk) begin
        if (reset)
            avsReadData <= 32'h0;
        else if (avsRead & ~ack_q)
            avsReadData <= rdMux;
        else if (accept)
            avsReadData <= avsReadData;
    end

    // LED time base
    wire slowPhase;
    wire fastPhase;

    ssms_blink #(.HALF_CYCLES(SLOW_HALF_CYCLES)) slowBlink (
        .clk   (clk),
        .reset (reset),
        .phase (slowPhase)
    );

    ssms_blink #(.HALF_CYCLES(FAST_HALF_CYCLES)) fastBlink (
        .clk   (clk),
        .reset (reset),
        .phase (fastPhase)
    );

    wire anyFault = overCurrent | underVoltage | overTemperature;
    wire deact    = opMode[2] | ~activation;

    always @(posedge clk) begin
        if (reset) begin
            stageDisabled <= 1'b1;
            ledGreen      <= 1'b0;
            ledRed        <= 1'b0;
        end else begin
            stageDisabled <= deact | anyFault;
            // A fault darkens green so the colours never mix
            if (anyFault)
                ledGreen <= 1'b0;
            else if (deact)
                ledGreen <= slowPhase;
            else
                ledGreen <= 1'b1;
            // Overcurrent is the most severe, so it masks the blink codes
            if (overCurrent)
                ledRed <= 1'b1;
            else if (overTemperature)
                ledRed <= fastPhase;
            else if (underVoltage)
                ledRed <= slowPhase;
            else
                ledRed <= 1'b0;
        end
    end
endmodule // ssms_mode_select

// ===== ssms_defines.vh
/*
 Constants for the stepper stage mode selector: register byte offsets,
 field positions, reset values, mode codes, step codes and blink timing.
 Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef SSMS_DEFINES_VH
`define SSMS_DEFINES_VH

// Register byte offsets (one aligned 32-bit word each)
`define SSMS_OFS_CONTROL      5'h00
`define SSMS_OFS_RUN_CURRENT  5'h04
`define SSMS_OFS_STOP_CURRENT 5'h08
`define SSMS_OFS_RESOLUTION   5'h0c
`define SSMS_OFS_STATUS       5'h10

// Control fields
`define SSMS_CTRL_LOCK_BIT    0

// Resolution register fields
`define SSMS_RES_CODE_MSB     3
`define SSMS_RES_DIR_BIT      4

// Status fields
`define SSMS_ST_MODE_LSB      0
`define SSMS_ST_DEACT_BIT     3
`define SSMS_ST_ADDR_LSB      4
`define SSMS_ST_RES_LSB       8
`define SSMS_ST_DIR_BIT       12
`define SSMS_ST_RANGE_BIT     13
`define SSMS_ST_OC_BIT        16
`define SSMS_ST_UV_BIT        17
`define SSMS_ST_OT_BIT        18

// Operating modes, one-hot
`define SSMS_MODE_SWITCH      3'h1
`define SSMS_MODE_BUS         3'h2
`define SSMS_MODE_DEACT       3'h4

// Step resolution codes
`define SSMS_STEP_1           4'h0
`define SSMS_STEP_2           4'h1
`define SSMS_STEP_4           4'h2
`define SSMS_STEP_5           4'h3
`define SSMS_STEP_8           4'h4
`define SSMS_STEP_10          4'h5
`define SSMS_STEP_16          4'h6
`define SSMS_STEP_20          4'h7
`define SSMS_STEP_32          4'h8
`define SSMS_STEP_64          4'h9
`define SSMS_STEP_128         4'ha
`define SSMS_STEP_256         4'hb
`define SSMS_STEP_512         4'hc

// Currents in units of 100 mA
`define SSMS_CUR_MIN          6'h01
`define SSMS_CUR_MAX          6'h32
`define SSMS_CUR_LOW_STEP     6'h01
`define SSMS_CUR_HIGH_STEP    6'h03
`define SSMS_CUR_LOW_BASE     6'h01
`define SSMS_CUR_HIGH_BASE    6'h02

// Reset values
`define SSMS_RST_CURRENT      6'h01
`define SSMS_RST_RES          4'h0
`define SSMS_RST_ADDR         4'h0

// Timing
`define SSMS_CLK_HZ           125000000
`define SSMS_SLOW_HALF_MS     1000
`define SSMS_FAST_HALF_MS     250

`endif

// ===== ssms_current_map.v
/*
 Maps one current switch position to a current in 100 mA units.
 Assumes position 1..F; position 0 is never used in switch mode.
*/
`timescale 1ns/1ps
`include "ssms_defines.vh"

module ssms_current_map (
    // Switch
    input  wire [3:0] position,
    input  wire       rangeHigh,
    // Result
    output reg  [5:0] tenthAmps
);
    wire [5:0] pos6 = {2'h0, position} - 6'h01;

    always @* begin
        if (rangeHigh)
            tenthAmps = `SSMS_CUR_HIGH_BASE + pos6 * `SSMS_CUR_HIGH_STEP;
        else
            tenthAmps = `SSMS_CUR_LOW_BASE + pos6 + `SSMS_CUR_LOW_STEP;
    end
endmodule // ssms_current_map

// ===== ssms_blink.v
/*
 Blink time base: divides the clock to a tick pulse and toggles a phase.
 Assumes HALF_CYCLES is at least 2.
*/
`timescale 1ns/1ps

module ssms_blink #(
    parameter HALF_CYCLES = 125000000
) (
    // Clock and reset
    input  wire clk,
    input  wire reset,
    // Blink phase
    output reg  phase
);
    localparam CW = $clog2(HALF_CYCLES);
    localparam integer  LAST_INT = HALF_CYCLES - 1;
    localparam [CW-1:0] LAST     = LAST_INT[CW-1:0];

    reg  [CW-1:0] count_q;
    wire          tick = (count_q == LAST);

    always @(posedge clk) begin
        if (reset) begin
            count_q <= {CW{1'b0}};
            phase   <= 1'b0;
        end else begin
            count_q <= tick ? {CW{1'b0}} : count_q + 1'b1;
            if (tick)
                phase <= ~phase;
        end
    end
endmodule // ssms_blink

// ===== ssms_checker_assertions.sv
/* Checker for the stepper stage mode selector, bound to ssms_mode_select.
   Assumes its ports only; the lock copy follows accepted control writes. */
`timescale 1ns/1ps
`include "ssms_defines.vh"
module ssms_checker #(
    parameter SLOW_HALF_CYCLES = 8,
    parameter FAST_HALF_CYCLES = 2
) (
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Bus
    input wire [4:0]  avsAddress,
    input wire        avsRead,
    input wire        avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0]  avsByteEnable,
    input wire [31:0] avsReadData,
    input wire        avsWaitRequest,
    // Panel and stage
    input wire [3:0]  run_current_switch,
    input wire [3:0]  stop_current_switch,
    input wire [3:0]  resolution_direction_switch,
    input wire        resetIn,
    input wire        activation,
    input wire        overCurrent,
    input wire        underVoltage,
    input wire        overTemperature,
    // Outputs
    input wire [2:0]  opMode,
    input wire [5:0]  runCurrent,
    input wire        ledGreen,
    input wire        ledRed
);
    reg        lock_q;
    reg [7:0]  steady_q;
    reg [7:0]  greenRun_q;
    reg [7:0]  redRun_q;
    reg [6:0]  prev_q;
    wire       accept = avsWrite && !avsWaitRequest && avsByteEnable[0];
    wire       faults = overCurrent | underVoltage | overTemperature;
    wire       idle   = !faults && (!activation || opMode == `SSMS_MODE_DEACT);
    wire [6:0] stage  = {activation, overCurrent, underVoltage, overTemperature, opMode};
    wire [2:0] zeros  = {run_current_switch == 4'h0, stop_current_switch == 4'h0,
                         resolution_direction_switch == 4'h0};
    wire [2:0] expMode = &zeros ? `SSMS_MODE_BUS : |zeros ? `SSMS_MODE_DEACT : `SSMS_MODE_SWITCH;
    wire [5:0] wd = avsWriteData[5:0];
    wire [5:0] clampRun = (wd == 6'h00) ? 6'h01 : (wd > 6'h32) ? 6'h32 : wd;

    // Run lengths are compared only once the stage inputs have settled
    always @(posedge clk) begin
        prev_q <= stage;
        greenRun_q <= ledGreen ? greenRun_q + 8'h01 : 8'h00;
        redRun_q <= ledRed ? redRun_q + 8'h01 : 8'h00;
        if (reset || stage != prev_q) steady_q <= 8'h00;
        else if (steady_q != 8'hff) steady_q <= steady_q + 8'h01;
        if (reset) lock_q <= 1'b0;
        else if (accept && avsAddress == `SSMS_OFS_CONTROL) lock_q <= avsWriteData[0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_wait_once: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
        else $error("wait state count wrong");
    a_unmapped_zero: assert property (avsRead && !avsWaitRequest && avsAddress[1:0] != 2'h0
        |-> avsReadData == 32'h0) else $error("unmapped read not zero");
    a_mode_decode: assert property ($rose(resetIn) && !lock_q |-> ##2 opMode == expMode)
        else $error("mode decode wrong");
    a_lock_bus: assert property ($rose(resetIn) && lock_q |-> ##2 opMode == `SSMS_MODE_BUS)
        else $error("lock did not hold bus mode");
    a_run_write: assert property (accept && avsAddress == `SSMS_OFS_RUN_CURRENT
        |=> ##[0:1] runCurrent == $past(clampRun)) else $error("run current write lost");
    a_green_ready: assert property (activation && !faults && opMode != `SSMS_MODE_DEACT
        |=> ledGreen) else $error("green not steady");
    a_red_over: assert property (overCurrent |=> ledRed && !ledGreen)
        else $error("overcurrent indication wrong");
    a_green_blink: assert property (steady_q > 8'h14 && idle && $fell(ledGreen)
        |-> greenRun_q == SLOW_HALF_CYCLES) else $error("green blink period wrong");
    a_red_fast: assert property (steady_q > 8'h14 && overTemperature && !overCurrent
        && $fell(ledRed) |-> redRun_q == FAST_HALF_CYCLES) else $error("red fast blink wrong");
    a_red_slow: assert property (steady_q > 8'h14 && underVoltage && !overCurrent
        && !overTemperature && $fell(ledRed) |-> redRun_q == SLOW_HALF_CYCLES)
        else $error("red slow blink wrong");

    c_lock_load: cover property ($rose(resetIn) && lock_q);
    c_deact_blink: cover property (opMode == `SSMS_MODE_DEACT && $fell(ledGreen));
    c_hot_blink: cover property (overTemperature && $fell(ledRed));
endmodule // ssms_checker

bind ssms_mode_select ssms_checker #(
    .SLOW_HALF_CYCLES(SLOW_HALF_CYCLES),
    .FAST_HALF_CYCLES(FAST_HALF_CYCLES)
) chk (
    .clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .run_current_switch(run_current_switch), .stop_current_switch(stop_current_switch),
    .resolution_direction_switch(resolution_direction_switch), .resetIn(resetIn),
    .activation(activation), .overCurrent(overCurrent), .underVoltage(underVoltage),
    .overTemperature(overTemperature), .opMode(opMode), .runCurrent(runCurrent),
    .ledGreen(ledGreen), .ledRed(ledRed)
);

// ===== ssms_panel.sv
/* Front panel and operator model: rotary switches and the reset input.
   Assumes one apply pulse per change; quiet suppresses the reset. */
`timescale 1ns/1ps
module ssms_panel (
    // Clock
    input  wire        clk,
    // Operator request
    input  wire [15:0] setting,
    input  wire        apply,
    input  wire        quiet,
    // Front panel
    output reg  [3:0]  address_switch,
    output reg  [3:0]  run_current_switch,
    output reg  [3:0]  stop_current_switch,
    output reg  [3:0]  resolution_direction_switch,
    output reg         resetIn
);
    reg [2:0] seq_q = 3'h0;
    reg       quiet_q = 1'b0;
    initial {address_switch, run_current_switch, stop_current_switch,
             resolution_direction_switch, resetIn} = 17'h00000;
    // Single device on the bus, so its address is never shared
    always @(posedge clk) begin
        if (apply) begin
            {address_switch, run_current_switch, stop_current_switch,
             resolution_direction_switch} <= setting;
            seq_q <= 3'h1;
            quiet_q <= quiet;
        end else if (seq_q != 3'h0) seq_q <= seq_q + 3'h1;
        resetIn <= !quiet_q && seq_q >= 3'h2 && seq_q <= 3'h4;
    end
endmodule // ssms_panel

// ===== stepper_stage_mode_select_test.sv
/* Self-checking bench for ssms_mode_select with the panel model.
   Assumes short blink divisors and an Avalon master in tasks. */
`timescale 1ns/1ps
`include "ssms_defines.vh"
module stepper_stage_mode_select_test;
    reg clk = 1'b0, reset = 1'b1, apply = 1'b0, quiet = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    reg rangeHigh = 1'b0, activation = 1'b1, overCurrent = 1'b0;
    reg underVoltage = 1'b0, overTemperature = 1'b0;
    reg [4:0] avsAddress = 5'h00;
    reg [31:0] avsWriteData = 32'h0, rd;
    reg [3:0] avsByteEnable = 4'hf, a, r, s, pend;
    reg [15:0] setting = 16'h0000;
    reg [5:0] v;
    wire [31:0] avsReadData;
    wire avsWaitRequest, resetIn, reverseDirection, stageDisabled, ledGreen, ledRed;
    wire [3:0] sw1, sw2, sw3, sw4, busAddress, stepResolution;
    wire [2:0] opMode;
    wire [5:0] runCurrent, stopCurrent;
    integer n_fail = 0, total_checks = 0, i, seedInit;
    always #4 clk = ~clk;

    ssms_panel panel (.clk(clk), .setting(setting), .apply(apply), .quiet(quiet),
        .address_switch(sw1), .run_current_switch(sw2), .stop_current_switch(sw3),
        .resolution_direction_switch(sw4), .resetIn(resetIn));
    ssms_mode_select #(.SLOW_HALF_CYCLES(8), .FAST_HALF_CYCLES(2)) uut (.clk(clk), .reset(reset),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .address_switch(sw1), .run_current_switch(sw2),
        .stop_current_switch(sw3), .resolution_direction_switch(sw4), .rangeHigh(rangeHigh),
        .resetIn(resetIn), .activation(activation), .overCurrent(overCurrent),
        .underVoltage(underVoltage), .overTemperature(overTemperature), .opMode(opMode),
        .busAddress(busAddress), .runCurrent(runCurrent), .stopCurrent(stopCurrent),
        .stepResolution(stepResolution), .reverseDirection(reverseDirection),
        .stageDisabled(stageDisabled), .ledGreen(ledGreen), .ledRed(ledRed));

    function [5:0] expCur(input [3:0] p, input h);
        expCur = h ? 6'h02 + 6'h03 * ({2'h0, p} - 6'h01) : {2'h0, p} + 6'h01;
    endfunction
    function [3:0] expStep(input [3:0] p);
        reg [3:0] k;
        begin
            k = (p == 4'hf) ? 4'h0 : (p - 4'h1) % 4'h7;
            expStep = (k == 4'h6) ? `SSMS_STEP_20 : k;
        end
    endfunction
    task check(input [8*5-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task bus(input wr, input [4:0] ad, input [31:0] wd);
        begin
            avsAddress <= ad;
            avsWriteData <= wd;
            avsWrite <= wr;
            avsRead <= !wr;
            @(posedge clk);
            while (avsWaitRequest !== 1'b0) @(posedge clk);
            rd = avsReadData;
            avsWrite <= 1'b0;
            avsRead <= 1'b0;
            @(posedge clk);
        end
    endtask
    task apply_sw(input [15:0] val, input q);
        begin
            setting <= val;
            quiet <= q;
            apply <= 1'b1;
            @(posedge clk);
            apply <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask
    task final_report;
        begin
            if (n_fail == 0 && total_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    initial begin
        #200000;
        n_fail = n_fail + 1;
        final_report;
    end

    initial begin
        seedInit = $urandom(7);
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check("mode", `SSMS_MODE_BUS, opMode);
        check("run", `SSMS_RST_CURRENT, runCurrent);
        for (i = 1; i < 16; i = i + 1) begin
            a = $urandom;
            r = (i == 1) ? 4'h1 : (i == 15) ? 4'hf : 4'h1 + $urandom % 15;
            s = 4'h1 + $urandom % 15;
            rangeHigh <= $urandom;
            apply_sw({a, r, s, i[3:0]}, 1'b0);
            check("mode", `SSMS_MODE_SWITCH, opMode);
            check("addr", a, busAddress);
            check("run", expCur(r, rangeHigh), runCurrent);
            check("stop", expCur(s, rangeHigh), stopCurrent);
            check("step", expStep(i[3:0]), stepResolution);
            check("dir", i >= 8, reverseDirection);
        end
        bus(1'b1, `SSMS_OFS_RUN_CURRENT, 32'h10);
        check("run", 6'h10, runCurrent);
        apply_sw(16'h0000, 1'b1);
        check("mode", `SSMS_MODE_SWITCH, opMode);
        check("run", 6'h10, runCurrent);
        apply_sw({a, r, s, 4'hf}, 1'b0);
        check("run", expCur(r, rangeHigh), runCurrent);
        for (i = 1; i < 7; i = i + 1) begin
            apply_sw({4'h2, i[0] ? 4'h0 : 4'h5, i[1] ? 4'h0 : 4'h6, i[2] ? 4'h0 : 4'h7}, 1'b0);
            check("mode", `SSMS_MODE_DEACT, opMode);
            check("dis", 1'b1, stageDisabled);
            repeat (48) @(posedge clk);
        end
        pend = 4'h0;
        for (i = 0; i < 13; i = i + 1) begin
            a = $urandom;
            bus(1'b1, `SSMS_OFS_RESOLUTION, {27'h0, i[0], i[3:0]});
            check("dir", i[0], reverseDirection);
            if (i > 0) check("step", pend, stepResolution);
            apply_sw({a, 12'h000}, 1'b0);
            pend = i[3:0];
            check("mode", `SSMS_MODE_BUS, opMode);
            check("addr", a, busAddress);
            check("step", i[3:0], stepResolution);
        end
        for (i = 0; i < 6; i = i + 1) begin
            v = (i < 5) ? 6'h00 + i * 13 : 6'h3f;
            bus(1'b1, `SSMS_OFS_STOP_CURRENT, {26'h0, v});
            check("stop", v == 6'h00 ? 6'h01 : v > 6'h32 ? 6'h32 : v, stopCurrent);
        end
        bus(1'b1, `SSMS_OFS_RESOLUTION, 32'h1f);
        bus(1'b0, `SSMS_OFS_RESOLUTION, 32'h0);
        check("res", 32'h1c, rd);
        bus(1'b1, `SSMS_OFS_CONTROL, 32'h1);
        bus(1'b0, `SSMS_OFS_CONTROL, 32'h0);
        check("lock", 1'b1, rd[0]);
        apply_sw(16'h3111, 1'b0);
        check("mode", `SSMS_MODE_BUS, opMode);
        check("addr", a, busAddress);
        bus(1'b1, 5'h14, 32'hffffffff);
        bus(1'b0, 5'h14, 32'h0);
        check("void", 32'h0, rd);
        bus(1'b0, 5'h15, 32'h0);
        check("void", 32'h0, rd);
        bus(1'b0, `SSMS_OFS_STATUS, 32'h0);
        check("stat", `SSMS_MODE_BUS, rd[2:0]);
        bus(1'b1, `SSMS_OFS_CONTROL, 32'h0);
        repeat (3) @(posedge clk);
        check("grn", 1'b1, ledGreen);
        overCurrent <= 1'b1;
        repeat (3) @(posedge clk);
        check("red", 1'b1, ledRed);
        check("grn", 1'b0, ledGreen);
        overCurrent <= 1'b0;
        overTemperature <= 1'b1;
        repeat (40) @(posedge clk);
        overTemperature <= 1'b0;
        underVoltage <= 1'b1;
        repeat (48) @(posedge clk);
        underVoltage <= 1'b0;
        activation <= 1'b0;
        repeat (48) @(posedge clk);
        final_report;
    end
endmodule // stepper_stage_mode_select_test
